// ### logic/snc_pkg.sv
/*
  Shared constants, types and table lookups for the sinc-cubed decimation filter.
  Assumes a single master clock domain and an AXI4-Lite master on the register side.
*/
`default_nettype none

package snc_pkg;

  // Modulator rate is the master clock divided by this figure.
  localparam int MOD_DIV      = 128;
  localparam int DIV_W        = $clog2(MOD_DIV);
  localparam int MCLK_REF_HZ  = 2457600;
  localparam int FMOD_REF_HZ  = MCLK_REF_HZ / MOD_DIV;

  // First notch (and output word rate) for each rate-select code, at the reference clock.
  localparam int RATE_0_HZ    = 50;
  localparam int RATE_1_HZ    = 60;
  localparam int RATE_2_HZ    = 100;
  localparam int RATE_3_HZ    = 500;

  localparam int STAGES       = 3;
  localparam int N_W          = 9;
  localparam int ACC_W        = 28;
  localparam int RECIP_W      = 26;
  localparam int RECIP_FRAC   = 40;
  localparam int OUT_W        = 16;
  localparam int SCALED_W     = OUT_W + 1;
  localparam int SCALE_SHIFT  = RECIP_FRAC - OUT_W;

  localparam logic [N_W-1:0] N_0 = N_W'(FMOD_REF_HZ / RATE_0_HZ);
  localparam logic [N_W-1:0] N_1 = N_W'(FMOD_REF_HZ / RATE_1_HZ);
  localparam logic [N_W-1:0] N_2 = N_W'(FMOD_REF_HZ / RATE_2_HZ);
  localparam logic [N_W-1:0] N_3 = N_W'(FMOD_REF_HZ / RATE_3_HZ);

  localparam int SYNC_SETTLE_PERIODS = 3;
  localparam int STEP_SETTLE_PERIODS = 4;
  localparam int DISCARD_W           = 3;

  localparam int AXI_AW                 = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL_OFF   = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS_OFF = 8'h04;
  localparam logic [AXI_AW-1:0] REG_DATA_OFF   = 8'h08;
  localparam int CTRL_RATE_LO_BIT       = 0;
  localparam int CTRL_RATE_HI_BIT       = 1;
  localparam int CTRL_BIPOLAR_BIT       = 2;
  localparam int CTRL_SYNC_BIT          = 3;
  localparam int STATUS_READY_BIT       = 0;
  localparam int STATUS_SETTLED_BIT     = 1;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam logic [SCALED_W-1:0] HALF_SCALE = 17'h08000;
  localparam logic [OUT_W-1:0]    FULL_CODE  = 16'hFFFF;

  typedef struct packed {
    logic       bipolar;
    logic [1:0] rate;
  } snc_ctrl_s;

  localparam snc_ctrl_s CTRL_RESET = '{bipolar: 1'b0, rate: 2'h0};

  typedef enum logic [1:0] {
    ST_FLUSH = 2'h0,
    ST_LAST  = 2'h1,
    ST_VALID = 2'h3
  } snc_state_e;

  typedef enum logic [1:0] {
    REG_CTRL   = 2'h0,
    REG_STATUS = 2'h1,
    REG_DATA   = 2'h2,
    REG_NONE   = 2'h3
  } snc_reg_e;

  function automatic logic [RECIP_W-1:0] recip_calc(input logic [N_W-1:0] n);
    longint c;
    c = longint'(n) * longint'(n) * longint'(n);
    return RECIP_W'((longint'(1) << RECIP_FRAC) / c);
  endfunction

  localparam logic [RECIP_W-1:0] RECIP_0 = recip_calc(N_0);
  localparam logic [RECIP_W-1:0] RECIP_1 = recip_calc(N_1);
  localparam logic [RECIP_W-1:0] RECIP_2 = recip_calc(N_2);
  localparam logic [RECIP_W-1:0] RECIP_3 = recip_calc(N_3);

  function automatic logic [N_W-1:0] n_of_rate(input logic [1:0] rate);
    case (rate)
      2'h0:    return N_0;
      2'h1:    return N_1;
      2'h2:    return N_2;
      default: return N_3;
    endcase
  endfunction

  function automatic logic [RECIP_W-1:0] recip_of_rate(input logic [1:0] rate);
    case (rate)
      2'h0:    return RECIP_0;
      2'h1:    return RECIP_1;
      2'h2:    return RECIP_2;
      default: return RECIP_3;
    endcase
  endfunction

endpackage

`default_nettype wire

// ### logic/snc_integrator.sv
/*
  Three cascaded integrators running at the modulator sample rate.
  Assumes sample_i is a one-cycle strobe and bit_i is already synchronised.
*/
`timescale 1ns/100ps
`default_nettype none

module snc_integrator
(
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  input  wire logic                      clear_i,
  input  wire logic                      sample_i,
  input  wire logic                      bit_i,
  output logic [snc_pkg::ACC_W-1:0]      acc_o
);

  logic [snc_pkg::ACC_W-1:0] acc  [snc_pkg::STAGES];
  logic [snc_pkg::ACC_W-1:0] feed [snc_pkg::STAGES];

  assign feed[0] = {{(snc_pkg::ACC_W-1){1'b0}}, bit_i};

  // Wrap-around is harmless: the combs difference it away while the width covers N cubed.
  genvar g;
  generate
    for (g = 0; g < snc_pkg::STAGES; g++)
    begin : g_stage
      if (g > 0)
      begin : g_feed
        assign feed[g] = acc[g-1];
      end
      always_ff @(posedge clock_i)
      begin
        if (reset_i || clear_i)
          acc[g] <= '0;
        else if (sample_i)
          acc[g] <= acc[g] + feed[g]; // R02
      end
    end
  endgenerate

  assign acc_o = acc[snc_pkg::STAGES-1];

endmodule

`default_nettype wire

// ### logic/snc_comb.sv
/*
  Three cascaded combs running at the decimated rate.
  Assumes take_i strobes once per output period, one cycle after the integrators moved.
*/
`timescale 1ns/100ps
`default_nettype none

module snc_comb
(
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  input  wire logic                      clear_i,
  input  wire logic                      take_i,
  input  wire logic [snc_pkg::ACC_W-1:0] acc_i,
  output logic [snc_pkg::ACC_W-1:0]      result_o,
  output logic                           valid_o
);

  logic [snc_pkg::ACC_W-1:0] diff [snc_pkg::STAGES+1];
  logic [snc_pkg::ACC_W-1:0] prev [snc_pkg::STAGES];

  assign diff[0] = acc_i;

  genvar g;
  generate
    for (g = 0; g < snc_pkg::STAGES; g++)
    begin : g_stage
      assign diff[g+1] = diff[g] - prev[g]; // R02
      always_ff @(posedge clock_i)
      begin
        if (reset_i || clear_i)
          prev[g] <= '0;
        else if (take_i)
          prev[g] <= diff[g];
      end
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      result_o <= '0;
    else if (take_i)
      result_o <= diff[snc_pkg::STAGES];
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      valid_o <= 1'b0;
    else
      valid_o <= take_i && !clear_i;
  end

endmodule

`default_nettype wire

// ### logic/snc_decimator.sv
/*
  Sinc-cubed decimation filter with an AXI4-Lite register slave.
  Assumes mod_bit_i arrives asynchronously from the modulator, which is clocked by mod_clk_o.
*/
// Behaviour
// R01 - Polarity bit changes only output coding (a polarity-only write also clears ready and restarts four-period settling)
// R02 - Three cascaded running sums of N
// R03 - N is modulator rate over word rate
// R04 - Rate field sets notch, same shape
// R05 - Notches at multiples of first notch
// R06 - Datapath headroom beyond nominal full scale
// R07 - Unsynchronised change: up to four periods invalid
// R08 - Filter sync: valid after three periods
// R09 - No rejection near sample-rate multiples
// R10 - Modulator samples at master clock/128
// R11 - Rate field spans 50 to 500 Hz
// R12 - Each period loads word, flags ready
`timescale 1ns/100ps
`default_nettype none

module snc_decimator
(
  input  wire logic                       clock_i,
  input  wire logic                       reset_i,
  input  wire logic [snc_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  output logic [1:0]                      s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  input  wire logic [snc_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  output logic [31:0]                     s_axi_rdata_o,
  output logic [1:0]                      s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  input  wire logic                       mod_bit_i,
  output logic                            mod_clk_o,
  output logic                            data_ready_o
);

  localparam int MOD_PERIOD = snc_pkg::MOD_DIV;

  function automatic snc_pkg::snc_reg_e reg_of(input logic [snc_pkg::AXI_AW-1:0] addr);
    if (addr == snc_pkg::REG_CTRL_OFF)
      return snc_pkg::REG_CTRL;
    else if (addr == snc_pkg::REG_STATUS_OFF)
      return snc_pkg::REG_STATUS;
    else if (addr == snc_pkg::REG_DATA_OFF)
      return snc_pkg::REG_DATA;
    else
      return snc_pkg::REG_NONE;
  endfunction

  function automatic logic [snc_pkg::OUT_W-1:0] code_of(input logic [snc_pkg::SCALED_W-1:0] s,
                                                        input logic                         bipolar);
    logic [snc_pkg::SCALED_W:0] u;
    // Doubling with the low bit copied lets a full-density input reach the top code.
    u = {(s - snc_pkg::HALF_SCALE), s[0]};
    if (bipolar)
      return (s > {1'b0, snc_pkg::FULL_CODE}) ? snc_pkg::FULL_CODE : s[snc_pkg::OUT_W-1:0];
    else if (s < snc_pkg::HALF_SCALE)
      return '0;
    else if (u > {2'b00, snc_pkg::FULL_CODE})
      return snc_pkg::FULL_CODE;
    else
      return u[snc_pkg::OUT_W-1:0];
  endfunction

  logic [1:0]                         bit_sync;
  logic [snc_pkg::DIV_W-1:0]          div_cnt;
  logic                               sample_stb;
  logic [snc_pkg::N_W-1:0]            dec_cnt;
  logic                               decim_stb;
  snc_pkg::snc_ctrl_s                 ctrl;
  snc_pkg::snc_ctrl_s                 next_ctrl;
  logic                               sync_pulse;
  logic                               step_pulse;
  logic [snc_pkg::N_W-1:0]            n_sel;
  logic [snc_pkg::RECIP_W-1:0]        recip_sel;
  logic [snc_pkg::ACC_W-1:0]          integ_acc;
  logic [snc_pkg::ACC_W-1:0]          comb_out;
  logic                               comb_valid;
  logic [snc_pkg::SCALED_W-1:0]       scaled;
  logic                               scaled_valid;
  snc_pkg::snc_state_e                state;
  logic [snc_pkg::DISCARD_W-1:0]      discard_left;
  logic                               load_pulse;
  logic [snc_pkg::OUT_W-1:0]          data_word;
  logic                               aw_got;
  logic                               w_got;
  logic [snc_pkg::AXI_AW-1:0]         awaddr_q;
  logic [31:0]                        wdata_q;
  logic [3:0]                         wstrb_q;
  logic                               wr_fire;
  logic                               rd_fire;
  logic                               ctrl_wr;
  logic                               data_rd;

  assign n_sel     = snc_pkg::n_of_rate(ctrl.rate); // R03 R11
  assign recip_sel = snc_pkg::recip_of_rate(ctrl.rate);
  assign wr_fire   = aw_got && w_got && !s_axi_bvalid_o;
  assign rd_fire   = s_axi_arvalid_i && s_axi_arready_o;
  assign ctrl_wr   = wr_fire && (reg_of(awaddr_q) == snc_pkg::REG_CTRL) && wstrb_q[0];
  assign data_rd   = rd_fire && (reg_of(s_axi_araddr_i) == snc_pkg::REG_DATA);
  assign next_ctrl = '{bipolar: wdata_q[snc_pkg::CTRL_BIPOLAR_BIT],
                       rate: {wdata_q[snc_pkg::CTRL_RATE_HI_BIT], wdata_q[snc_pkg::CTRL_RATE_LO_BIT]}};

  // The first stage is read only by the second, to keep metastability out of the sum.
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      bit_sync <= 2'h0;
    else
      bit_sync <= {bit_sync[0], mod_bit_i};
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      div_cnt    <= '0;
      sample_stb <= 1'b0;
      mod_clk_o  <= 1'b0;
    end
    else
    begin
      div_cnt    <= div_cnt + 1'b1; // R10
      sample_stb <= (div_cnt == snc_pkg::DIV_W'(snc_pkg::MOD_DIV - 1)); // R10
      mod_clk_o  <= div_cnt[snc_pkg::DIV_W-1];
    end
  end

  // Counting with >= lets a shorter ratio take over cleanly after a rate change.
  always_ff @(posedge clock_i)
  begin
    if (reset_i || sync_pulse)
    begin
      dec_cnt   <= '0;
      decim_stb <= 1'b0;
    end
    else
    begin
      decim_stb <= sample_stb && (dec_cnt >= n_sel - 1'b1); // R03 R04 R05
      if (sample_stb)
        dec_cnt <= (dec_cnt >= n_sel - 1'b1) ? '0 : dec_cnt + 1'b1;
    end
  end

  snc_integrator u_integrator
  (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .clear_i  (sync_pulse),
    .sample_i (sample_stb),
    .bit_i    (bit_sync[1]),
    .acc_o    (integ_acc)
  );

  snc_comb u_comb
  (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .clear_i  (sync_pulse),
    .take_i   (decim_stb),
    .acc_i    (integ_acc),
    .result_o (comb_out),
    .valid_o  (comb_valid)
  );

  // Scaling by a per-rate reciprocal keeps the response shape the same at every rate; no
  // rejection is added near sample-rate multiples, so those bands still pass.
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      scaled       <= '0;
      scaled_valid <= 1'b0;
    end
    else
    begin
      scaled_valid <= comb_valid && !sync_pulse;
      if (comb_valid)
        scaled <= snc_pkg::SCALED_W'((64'(comb_out) * 64'(recip_sel)) >> snc_pkg::SCALE_SHIFT); // R02 R04 R06 R09
    end
  end

  assign load_pulse = scaled_valid && (state != snc_pkg::ST_FLUSH);

  always_ff @(posedge clock_i)
  begin
    if (reset_i || sync_pulse)
    begin
      state        <= snc_pkg::ST_FLUSH;
      discard_left <= snc_pkg::DISCARD_W'(snc_pkg::SYNC_SETTLE_PERIODS - 1); // R08
    end
    else if (step_pulse)
    begin
      state        <= snc_pkg::ST_FLUSH;
      discard_left <= snc_pkg::DISCARD_W'(snc_pkg::STEP_SETTLE_PERIODS - 1); // R07
    end
    else if (scaled_valid)
    begin
      case (state)
        snc_pkg::ST_FLUSH:
        begin
          if (discard_left == snc_pkg::DISCARD_W'(1))
            state <= snc_pkg::ST_LAST;
          else
            discard_left <= discard_left - 1'b1;
        end
        snc_pkg::ST_LAST:
          state <= snc_pkg::ST_VALID;
        default:
          state <= snc_pkg::ST_VALID;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      data_word <= '0;
    else if (load_pulse)
      data_word <= code_of(scaled, ctrl.bipolar); // R01 R12
  end

  // A new word in the same cycle as a data read keeps the flag set.
  always_ff @(posedge clock_i)
  begin
    if (reset_i || sync_pulse || step_pulse)
      data_ready_o <= 1'b0;
    else if (load_pulse)
      data_ready_o <= 1'b1; // R12
    else if (data_rd)
      data_ready_o <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      ctrl       <= snc_pkg::CTRL_RESET;
      sync_pulse <= 1'b0;
      step_pulse <= 1'b0;
    end
    else
    begin
      sync_pulse <= ctrl_wr && wdata_q[snc_pkg::CTRL_SYNC_BIT]; // R08
      step_pulse <= ctrl_wr && !wdata_q[snc_pkg::CTRL_SYNC_BIT] && (next_ctrl != ctrl); // R07
      if (ctrl_wr)
        ctrl <= next_ctrl; // R01 R04
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      s_axi_awready_o <= 1'b0;
      aw_got          <= 1'b0;
      awaddr_q        <= '0;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      s_axi_awready_o <= 1'b0;
      aw_got          <= 1'b1;
      awaddr_q        <= s_axi_awaddr_i;
    end
    else if (s_axi_bvalid_o && s_axi_bready_i)
      aw_got <= 1'b0;
    else if (!aw_got && !s_axi_bvalid_o)
      s_axi_awready_o <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      s_axi_wready_o <= 1'b0;
      w_got          <= 1'b0;
      wdata_q        <= '0;
      wstrb_q        <= '0;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      s_axi_wready_o <= 1'b0;
      w_got          <= 1'b1;
      wdata_q        <= s_axi_wdata_i;
      wstrb_q        <= s_axi_wstrb_i;
    end
    else if (s_axi_bvalid_o && s_axi_bready_i)
      w_got <= 1'b0;
    else if (!w_got && !s_axi_bvalid_o)
      s_axi_wready_o <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= snc_pkg::RESP_OKAY;
    end
    else if (s_axi_bvalid_o && s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
    else if (wr_fire)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (reg_of(awaddr_q) == snc_pkg::REG_NONE) ? snc_pkg::RESP_SLVERR : snc_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= snc_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rresp_o   <= snc_pkg::RESP_OKAY;
      s_axi_rdata_o   <= '0;
      if (reg_of(s_axi_araddr_i) == snc_pkg::REG_CTRL)
        s_axi_rdata_o[snc_pkg::CTRL_BIPOLAR_BIT:0] <= {ctrl.bipolar, ctrl.rate};
      else if (reg_of(s_axi_araddr_i) == snc_pkg::REG_STATUS)
      begin
        s_axi_rdata_o[snc_pkg::STATUS_READY_BIT]   <= data_ready_o;
        s_axi_rdata_o[snc_pkg::STATUS_SETTLED_BIT] <= (state == snc_pkg::ST_VALID);
      end
      else if (reg_of(s_axi_araddr_i) == snc_pkg::REG_DATA)
        s_axi_rdata_o[snc_pkg::OUT_W-1:0] <= data_word;
      else
        s_axi_rresp_o <= snc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
    else if (!s_axi_rvalid_o)
      s_axi_arready_o <= 1'b1;
  end

  sample_period_a: assert property (@(posedge clock_i) disable iff (reset_i) // R10
    sample_stb |-> ##MOD_PERIOD sample_stb)
    else $error("modulator sample spacing is not the divider period");

  decim_ratio_a: assert property (@(posedge clock_i) disable iff (reset_i) // R03
    (sample_stb && dec_cnt == n_sel - 1'b1 && !sync_pulse) |=> decim_stb)
    else $error("decimation strobe missing after N samples");

  word_load_a: assert property (@(posedge clock_i) disable iff (reset_i) // R12
    (decim_stb && state == snc_pkg::ST_VALID && !sync_pulse && !step_pulse
      ##1 !sync_pulse && !step_pulse ##1 !sync_pulse && !step_pulse)
      |-> (load_pulse ##1 data_ready_o))
    else $error("period end did not load a word");

  sync_flush_a: assert property (@(posedge clock_i) disable iff (reset_i) // R08
    sync_pulse |=> (state == snc_pkg::ST_FLUSH && discard_left == 2'h2 && !data_ready_o))
    else $error("sync did not restart settling");

  step_flush_a: assert property (@(posedge clock_i) disable iff (reset_i) // R07
    (step_pulse && !sync_pulse) |=> (state == snc_pkg::ST_FLUSH && discard_left == 3'h3))
    else $error("rate change did not invalidate output");

  bipolar_code_a: assert property (@(posedge clock_i) disable iff (reset_i) // R01
    (load_pulse && ctrl.bipolar && scaled <= 17'h0FFFF) |=> data_word == $past(scaled[15:0]))
    else $error("bipolar coding wrong");

  unipolar_floor_a: assert property (@(posedge clock_i) disable iff (reset_i) // R01
    (load_pulse && !ctrl.bipolar && scaled < 17'h08000) |=> data_word == 16'h0000)
    else $error("unipolar coding wrong below midscale");

  headroom_a: assert property (@(posedge clock_i) disable iff (reset_i) // R06
    (comb_valid && state == snc_pkg::ST_VALID) |-> comb_out <= 28'(n_sel) * n_sel * n_sel)
    else $error("filter sum exceeded N cubed");

  flush_quiet_a: assert property (@(posedge clock_i) disable iff (reset_i) // R07
    (state == snc_pkg::ST_FLUSH) |-> !load_pulse)
    else $error("word presented while settling");

  bresp_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (s_axi_bvalid_o && !s_axi_bready_i) |=> (s_axi_bvalid_o && $stable(s_axi_bresp_o)))
    else $error("write response dropped before taken");

endmodule

`default_nettype wire

// ### verif/snc_mod_model.sv
/*
  Modulator stand-in that drives the bitstream into the decimation filter.
  Assumes the filter supplies the modulator clock and takes one sample per modulator cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module snc_mod_model
(
  input  wire logic       mod_clk_i,
  input  wire logic [1:0] mode_i,
  output logic            bit_o
);
  logic phase = 1'b0;

  // Mode 0 gives all zeros, 1 all ones, 2 alternating bits.
  // Bits move on the falling edge, on the same clock edge where the filter adds a sample.
  always @(negedge mod_clk_i)
  begin
    phase <= ~phase;
    bit_o <= (mode_i == 2'h1) | ((mode_i == 2'h2) & phase);
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/*
  Self-checking bench for the decimation filter, driven over its register bus.
  Assumes the modulator stand-in runs on mod_clk, which the filter derives from this bench's clock.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // One output period at the fastest rate code, in clocks.
  localparam int P = 38 * 128;
  logic        clock_i, reset_i, aw_valid, w_valid, b_ready, ar_valid, r_ready;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, data_ready, mod_clk, mod_bit;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data, d;
  logic [1:0]  b_resp, r_resp, rs, mode;
  int          n_errors, checks_done, cyc, t0, t1, t2;

  snc_decimator i_snc_decimator (.clock_i(clock_i), .reset_i(reset_i), .s_axi_awaddr_i(aw_addr),
    .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready), .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
    .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid),
    .s_axi_rready_i(r_ready), .mod_bit_i(mod_bit), .mod_clk_o(mod_clk), .data_ready_o(data_ready));

  snc_mod_model i_snc_mod_model (.mod_clk_i(mod_clk), .mode_i(mode), .bit_o(mod_bit));

  always #2 clock_i = ~clock_i;

  // The whole run needs about 55000 cycles; anything far beyond that is a hang.
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Range test kept four-state so an unknown never counts as inside.
  function automatic logic [31:0] rng(input logic [31:0] x, input logic [31:0] lo, input logic [31:0] hi);
    return {31'h0, (x >= lo && x <= hi)};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    aw_addr <= a;
    w_data <= dat;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    while (!(aw_d && w_d))
    begin
      @(posedge clock_i);
      if (!aw_d && aw_ready === 1'b1)
      begin
        aw_d = 1'b1;
        aw_valid <= 1'b0;
      end
      if (!w_d && w_ready === 1'b1)
      begin
        w_d = 1'b1;
        w_valid <= 1'b0;
      end
    end
    do @(posedge clock_i); while (b_valid !== 1'b1);
    check({30'h0, b_resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    ar_addr <= a;
    ar_valid <= 1'b1;
    do @(posedge clock_i); while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    do @(posedge clock_i); while (r_valid !== 1'b1);
    dat = r_data;
    rsp = r_resp;
  endtask

  task automatic wait_rdy(output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (data_ready !== 1'b1 && n < 25000);
    t = cyc;
  endtask

  initial
  begin
    clock_i = 1'b0;
    reset_i = 1'b1;
    // Response readies stay high for the whole run, so back-to-back calls never toggle them.
    {aw_valid, w_valid, b_ready, ar_valid, r_ready} = 5'h05;
    aw_addr = 8'h00;
    ar_addr = 8'h00;
    w_data = 32'h0;
    mode = 2'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rd(8'h00, d, rs);
    check(d, 32'h0);
    rd(8'h04, d, rs);
    check(d, 32'h0);
    rd(8'h0C, d, rs);
    check({30'h0, rs}, 32'h2);
    check(d, 32'h0);
    wr(8'h0C, 32'h0, 2'h2);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, {28'h0, 1'b1, i[0], i[1:0]}, 2'h0);
      rd(8'h00, d, rs);
      check(d, {29'h0, i[0], i[1:0]});
    end
    // Full-density input, synchronised start at the fastest rate.
    mode <= 2'h1;
    // The stand-in moves bits only on its falling edge; let the new pattern arrive before sync.
    repeat (300) @(posedge clock_i);
    t0 = cyc;
    wr(8'h00, 32'hB, 2'h0);
    wait_rdy(t1);
    check(rng(t1 - t0, 3 * P - 140, 3 * P + 140), 32'h1);
    rd(8'h08, d, rs);
    check(d, 32'hFFFF);
    rd(8'h04, d, rs);
    check(d, 32'h2);
    check({31'h0, data_ready}, 32'h0);
    wait_rdy(t2);
    check(t2 - t1, P);
    rd(8'h08, d, rs);
    check(d, 32'hFFFF);
    // Half density reads mid-scale in bipolar coding and zero in unipolar.
    mode <= 2'h2;
    repeat (300) @(posedge clock_i);
    wr(8'h00, 32'hF, 2'h0);
    wait_rdy(t1);
    rd(8'h08, d, rs);
    check(rng(d, 32'h7FFF, 32'h8001), 32'h1);
    t0 = cyc;
    wr(8'h00, 32'h3, 2'h0);
    rd(8'h04, d, rs);
    check(d, 32'h0);
    wait_rdy(t1);
    check(rng(t1 - t0, 3 * P - 140, 4 * P + 140), 32'h1);
    rd(8'h08, d, rs);
    check(rng(d, 32'h0, 32'h1), 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
